/* core/fseq_cfg.svh */
`ifndef FSEQ_CFG_SVH
`define FSEQ_CFG_SVH

// Clock rate.
`define FSEQ_CLK_MHZ 25
`define FSEQ_CLK_NS 40

// Sector counts per bank.
`define FSEQ_NPRI 8
`define FSEQ_NSEC 4

// Unlock addresses and command codes on the data bus.
`define FSEQ_ADR_UNLK1 12'h555
`define FSEQ_ADR_UNLK2 12'haaa
`define FSEQ_CODE_UNLK1 8'haa
`define FSEQ_CODE_UNLK2 8'h55
`define FSEQ_CODE_PROG 8'ha0
`define FSEQ_CODE_ERASE 8'h80
`define FSEQ_CODE_BULK 8'h10
`define FSEQ_CODE_SECT 8'h30
`define FSEQ_CODE_BYP 8'h20
`define FSEQ_CODE_BYPX 8'h90
`define FSEQ_CODE_BYPX2 8'h00
`define FSEQ_CODE_SUSP 8'hb0
`define FSEQ_CODE_RESUME 8'h30
`define FSEQ_CODE_RESET 8'hf0

// Byte values.
`define FSEQ_ERASED 8'hff
`define FSEQ_PREPROG 8'h00

// Status bit positions.
`define FSEQ_POLL_BIT 7
`define FSEQ_TOG_BIT 6
`define FSEQ_FAIL_BIT 5
`define FSEQ_WIN_BIT 3

// Times and derived cycle counts.
`define FSEQ_PROG_US 14
`define FSEQ_PROG_CYC (`FSEQ_PROG_US * `FSEQ_CLK_MHZ)
`define FSEQ_WIN_US 100
`define FSEQ_WIN_CYC (`FSEQ_WIN_US * `FSEQ_CLK_MHZ)
`define FSEQ_SUSP_NS 100
`define FSEQ_SUSP_CYC ((`FSEQ_SUSP_NS + `FSEQ_CLK_NS - 1) / `FSEQ_CLK_NS)

`endif

/* core/fseq_pkg.sv */
package fseq_pkg;

  typedef enum logic [4:0] {
    FSEQ_READ,
    FSEQ_UNL1,
    FSEQ_UNL2,
    FSEQ_PROG_ADDR,
    FSEQ_ER0,
    FSEQ_ER1,
    FSEQ_ER2,
    FSEQ_PROG,
    FSEQ_FAIL,
    FSEQ_BYP,
    FSEQ_BYP_ADDR,
    FSEQ_BYP_EXIT,
    FSEQ_WINDOW,
    FSEQ_ERASE,
    FSEQ_SUSP_PEND,
    FSEQ_SUSPENDED,
    FSEQ_WIPE
  } fseq_state_type;

endpackage : fseq_pkg

/* core/fseq_flash_sequencer.sv */
`timescale 1ns/100ps
`include "fseq_cfg.svh"

module fseq_flash_sequencer
  import fseq_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int OFS_W = 4,
  parameter logic [31:0] ERASE_CYC = 32'h017d7840
) (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_in,
  // Microcontroller bus.
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Sector selects from the address decoder.
  input wire logic [`FSEQ_NPRI-1:0] primary_sector_selects_in,
  input wire logic [`FSEQ_NSEC-1:0] secondary_sector_selects_in,
  // Embedded algorithm fault and state.
  input wire logic alg_fault_in,
  output logic busy_out,
  output logic bypass_out
);

  localparam int NSECT = `FSEQ_NPRI + `FSEQ_NSEC;
  localparam int DEPTH = NSECT << OFS_W;
  localparam int IW = OFS_W + 4;
  localparam logic [IW-1:0] LAST = IW'(DEPTH - 1);

  if (ADDR_W < 12 || OFS_W < 1 || OFS_W > ADDR_W ||
      ERASE_CYC == 32'h0) begin : g_bad_param
    $error("fseq: width or erase cycle count not supported");
  end

  // Secondary selects win where both banks decode the same address.
  function automatic logic [3:0] sec_of(input logic [`FSEQ_NPRI-1:0] p,
                                        input logic [`FSEQ_NSEC-1:0] s);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < `FSEQ_NPRI; i++) begin
      if (p[i]) begin
        r = 4'(i);
      end
    end
    for (int i = 0; i < `FSEQ_NSEC; i++) begin
      if (s[i]) begin
        r = 4'(`FSEQ_NPRI + i);
      end
    end
    return r;
  endfunction : sec_of

  logic [7:0] mem [0:DEPTH-1];
  fseq_state_type state;
  logic ret_bypass;
  logic bulk;
  logic err;
  logic tog;
  logic [IW-1:0] tgt;
  logic [7:0] tgt_data;
  logic [NSECT-1:0] mask;
  logic [31:0] timer;
  logic [3:0] scnt;
  logic [IW:0] ptr;

  logic sel_any;
  logic wr;
  logic [3:0] cur_sec;
  logic [IW-1:0] cur_idx;
  logic [11:0] a12;
  logic bad_bits;
  logic prog_done;
  logic prog_commit;
  logic [3:0] wipe_sec;
  logic erasing;
  logic stat_hit;
  logic stat_rd;

  assign sel_any = |primary_sector_selects_in |
                   |secondary_sector_selects_in;
  assign wr = wr_in & sel_any;
  assign cur_sec = sec_of(primary_sector_selects_in,
                          secondary_sector_selects_in);
  assign cur_idx = {cur_sec, addr_in[OFS_W-1:0]};
  assign a12 = addr_in[11:0];
  assign bad_bits = |(tgt_data & ~mem[tgt]);
  assign prog_done = (state == FSEQ_PROG) && (timer == 32'h1);
  assign prog_commit = prog_done && !bad_bits && !alg_fault_in;
  assign wipe_sec = ptr[IW-1:OFS_W];
  assign erasing = (state == FSEQ_WINDOW) || (state == FSEQ_ERASE) ||
                   (state == FSEQ_SUSP_PEND) || (state == FSEQ_WIPE);
  always_comb begin
    stat_hit = 1'b0;
    if (state == FSEQ_PROG) begin
      stat_hit = (cur_idx == tgt);
    end else if (state == FSEQ_FAIL) begin
      stat_hit = (mask != '0) ? mask[cur_sec] : (cur_idx == tgt);
    end else if (erasing) begin
      stat_hit = mask[cur_sec];
    end
  end
  assign stat_rd = rd_in && sel_any && stat_hit;
  assign busy_out = (state == FSEQ_PROG) || erasing;
  assign bypass_out = (state == FSEQ_BYP) || (state == FSEQ_BYP_ADDR) ||
                      (state == FSEQ_BYP_EXIT) ||
                      ((state == FSEQ_PROG) && ret_bypass);

  // Command sequencer.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= FSEQ_READ;
      ret_bypass <= 1'b0;
      bulk <= 1'b0;
      err <= 1'b0;
      tgt <= '0;
      tgt_data <= 8'h00;
      mask <= '0;
      timer <= 32'h0;
      scnt <= 4'h0;
      ptr <= '0;
    end else begin
      unique case (state)
        FSEQ_READ: begin
          if (wr && a12 == `FSEQ_ADR_UNLK1 &&
              wdata_in == `FSEQ_CODE_UNLK1) begin
            state <= FSEQ_UNL1;
          end
        end
        FSEQ_UNL1: begin
          if (wr) begin
            state <= (a12 == `FSEQ_ADR_UNLK2 &&
                      wdata_in == `FSEQ_CODE_UNLK2) ?
                     FSEQ_UNL2 : FSEQ_READ;
          end
        end
        FSEQ_UNL2: begin
          if (wr) begin
            if (a12 == `FSEQ_ADR_UNLK1 && wdata_in == `FSEQ_CODE_PROG) begin
              state <= FSEQ_PROG_ADDR;
            end else if (a12 == `FSEQ_ADR_UNLK1 &&
                         wdata_in == `FSEQ_CODE_ERASE) begin
              state <= FSEQ_ER0;
            end else if (a12 == `FSEQ_ADR_UNLK1 &&
                         wdata_in == `FSEQ_CODE_BYP) begin
              state <= FSEQ_BYP;
            end else begin
              state <= FSEQ_READ;
            end
          end
        end
        FSEQ_PROG_ADDR, FSEQ_BYP_ADDR: begin
          if (wr) begin
            tgt <= cur_idx;
            tgt_data <= wdata_in;
            timer <= 32'(`FSEQ_PROG_CYC);
            ret_bypass <= (state == FSEQ_BYP_ADDR);
            mask <= '0;
            state <= FSEQ_PROG;
          end
        end
        FSEQ_PROG: begin
          timer <= timer - 32'h1;
          if (prog_done) begin
            if (bad_bits || alg_fault_in) begin
              err <= 1'b1;
              state <= FSEQ_FAIL;
            end else begin
              state <= ret_bypass ? FSEQ_BYP : FSEQ_READ;
            end
          end
        end
        FSEQ_FAIL: begin
          if (wr && wdata_in == `FSEQ_CODE_RESET) begin
            err <= 1'b0;
            ret_bypass <= 1'b0;
            mask <= '0;
            bulk <= 1'b0;
            state <= FSEQ_READ;
          end
        end
        FSEQ_ER0: begin
          if (wr) begin
            state <= (a12 == `FSEQ_ADR_UNLK1 &&
                      wdata_in == `FSEQ_CODE_UNLK1) ?
                     FSEQ_ER1 : FSEQ_READ;
          end
        end
        FSEQ_ER1: begin
          if (wr) begin
            state <= (a12 == `FSEQ_ADR_UNLK2 &&
                      wdata_in == `FSEQ_CODE_UNLK2) ?
                     FSEQ_ER2 : FSEQ_READ;
          end
        end
        FSEQ_ER2: begin
          if (wr) begin
            if (a12 == `FSEQ_ADR_UNLK1 && wdata_in == `FSEQ_CODE_BULK) begin
              mask <= '1;
              bulk <= 1'b1;
              timer <= ERASE_CYC;
              state <= FSEQ_ERASE;
            end else if (wdata_in == `FSEQ_CODE_SECT) begin
              mask <= NSECT'(1) << cur_sec;
              timer <= 32'(`FSEQ_WIN_CYC);
              state <= FSEQ_WINDOW;
            end else begin
              state <= FSEQ_READ;
            end
          end
        end
        FSEQ_BYP: begin
          if (wr && wdata_in == `FSEQ_CODE_PROG) begin
            state <= FSEQ_BYP_ADDR;
          end else if (wr && wdata_in == `FSEQ_CODE_BYPX) begin
            state <= FSEQ_BYP_EXIT;
          end
        end
        FSEQ_BYP_EXIT: begin
          if (wr) begin
            state <= (wdata_in == `FSEQ_CODE_BYPX2) ?
                     FSEQ_READ : FSEQ_BYP;
          end
        end
        FSEQ_WINDOW: begin
          timer <= timer - 32'h1;
          if (wr && wdata_in == `FSEQ_CODE_SECT) begin
            mask <= mask | (NSECT'(1) << cur_sec);
            timer <= 32'(`FSEQ_WIN_CYC);
          end else if (wr && wdata_in == `FSEQ_CODE_SUSP) begin
            timer <= ERASE_CYC;
            scnt <= 4'(`FSEQ_SUSP_CYC);
            state <= FSEQ_SUSP_PEND;
          end else if (wr) begin
            mask <= '0;
            state <= FSEQ_READ;
          end else if (timer == 32'h1) begin
            timer <= ERASE_CYC;
            state <= FSEQ_ERASE;
          end
        end
        FSEQ_ERASE: begin
          timer <= timer - 32'h1;
          if (alg_fault_in) begin
            err <= 1'b1;
            state <= FSEQ_FAIL;
          end else if (wr && !bulk && wdata_in == `FSEQ_CODE_SUSP) begin
            scnt <= 4'(`FSEQ_SUSP_CYC);
            state <= FSEQ_SUSP_PEND;
          end else if (wr && !bulk && wdata_in == `FSEQ_CODE_RESET) begin
            mask <= '0;
            state <= FSEQ_READ;
          end else if (timer == 32'h1) begin
            ptr <= '0;
            state <= FSEQ_WIPE;
          end
        end
        FSEQ_SUSP_PEND: begin
          scnt <= scnt - 4'h1;
          if (scnt == 4'h1) begin
            state <= FSEQ_SUSPENDED;
          end
        end
        FSEQ_SUSPENDED: begin
          if (wr && wdata_in == `FSEQ_CODE_RESUME) begin
            state <= FSEQ_ERASE;
          end else if (wr && wdata_in == `FSEQ_CODE_RESET) begin
            mask <= '0;
            state <= FSEQ_READ;
          end
        end
        FSEQ_WIPE: begin
          if (ptr[IW-1:0] == LAST) begin
            ptr <= {1'b1, {IW{1'b0}}};
            if (ptr[IW]) begin
              mask <= '0;
              bulk <= 1'b0;
              state <= FSEQ_READ;
            end
          end else begin
            ptr <= ptr + (IW+1)'(1);
          end
        end
      endcase
    end
  end

  // The array has no reset; power-up contents are left to the cells.
  always_ff @(posedge mclk_in) begin
    if (prog_commit) begin
      mem[tgt] <= mem[tgt] & tgt_data;
    end else if (state == FSEQ_WIPE && mask[wipe_sec]) begin
      mem[ptr[IW-1:0]] <= ptr[IW] ? `FSEQ_ERASED : `FSEQ_PREPROG;
    end
  end

  // Status toggles once per status read so two reads always differ.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tog <= 1'b0;
    end else if (stat_rd) begin
      tog <= ~tog;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      if (!sel_any) begin
        rdata_out <= 8'h00;
      end else if (stat_hit) begin
        rdata_out <= 8'h00;
        rdata_out[`FSEQ_POLL_BIT] <= (state == FSEQ_PROG ||
                                      (state == FSEQ_FAIL && mask == '0)) ?
                                     ~tgt_data[7] : 1'b0;
        rdata_out[`FSEQ_TOG_BIT] <= tog;
        rdata_out[`FSEQ_FAIL_BIT] <= err;
        rdata_out[`FSEQ_WIN_BIT] <= erasing &&
                                    (state != FSEQ_WINDOW);
      end else begin
        rdata_out <= mem[cur_idx];
      end
    end
  end

  // Checking helpers.
  // Taken at the read itself, so reads with no gap still pair up.
  logic have_prev;
  logic prev_b6;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      have_prev <= 1'b0;
      prev_b6 <= 1'b0;
    end else if (!busy_out) begin
      have_prev <= 1'b0;
    end else if (stat_rd) begin
      have_prev <= 1'b1;
      prev_b6 <= tog;
    end
  end

  sequence s_suspend_req;
    state == FSEQ_ERASE && !bulk && !alg_fault_in && wr &&
    wdata_in == `FSEQ_CODE_SUSP;
  endsequence

  sequence s_suspend_pend;
    state == FSEQ_SUSP_PEND [*3];
  endsequence

  a_prog_poll_inv: assert property (@(posedge mclk_in) disable iff (rst_in)
    stat_rd && state == FSEQ_PROG |=> rdata_out[7] == ~$past(tgt_data[7]))
    else $error("poll bit not inverted during program");
  a_erase_poll_zero: assert property (@(posedge mclk_in) disable iff (rst_in)
    stat_rd && erasing |=> !rdata_out[7] && rdata_out[5] == $past(err))
    else $error("poll bit not zero during erase");
  a_toggle_flip: assert property (@(posedge mclk_in) disable iff (rst_in)
    stat_rd && have_prev |=> rdata_out[6] != $past(prev_b6))
    else $error("toggle bit did not invert");
  a_window_bit: assert property (@(posedge mclk_in) disable iff (rst_in)
    stat_rd && erasing |=> rdata_out[3] == ($past(state) != FSEQ_WINDOW))
    else $error("window bit wrong");
  a_bulk_ignore: assert property (@(posedge mclk_in) disable iff (rst_in)
    state == FSEQ_ERASE && bulk && wr |=> state != FSEQ_READ &&
    state != FSEQ_SUSP_PEND)
    else $error("bulk erase took a command");
  a_suspend_stop: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_suspend_req |=> s_suspend_pend ##1 state == FSEQ_SUSPENDED)
    else $error("suspend did not settle in time");
  a_bypass_ignore: assert property (@(posedge mclk_in) disable iff (rst_in)
    state == FSEQ_BYP && wr && wdata_in != `FSEQ_CODE_PROG &&
    wdata_in != `FSEQ_CODE_BYPX |=> state == FSEQ_BYP)
    else $error("bypass took a foreign command");
  a_seq_abort: assert property (@(posedge mclk_in) disable iff (rst_in)
    state == FSEQ_ER1 && wr && wdata_in != `FSEQ_CODE_UNLK2 |=>
    state == FSEQ_READ)
    else $error("bad erase write did not abort");
  a_fail_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
    prog_done && bad_bits |=> state == FSEQ_FAIL && err)
    else $error("one-over-zero not flagged");
  a_win_restart: assert property (@(posedge mclk_in) disable iff (rst_in)
    state == FSEQ_WINDOW && wr && wdata_in == `FSEQ_CODE_SECT |=>
    timer == 32'(`FSEQ_WIN_CYC) && state == FSEQ_WINDOW)
    else $error("window not restarted");

endmodule : fseq_flash_sequencer

/* bench/fseq_mcu.sv */
`timescale 1ns/100ps
`include "fseq_cfg.svh"

module fseq_mcu (
  // Bus clock.
  input wire logic mclk_in,
  // Bus towards the sequencer.
  output logic [15:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] psel_out,
  output logic [3:0] ssel_out,
  input wire logic [7:0] rdata_in
);
  initial begin
    addr_out = 16'h0000;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    psel_out = 8'h00;
    ssel_out = 4'h0;
  end

  // Sector numbers from 8 upward sit in the secondary bank.
  task automatic sel(input int s);
    psel_out <= (s < 8) ? 8'h01 << s : 8'h00;
    ssel_out <= (s >= 8) ? 4'h1 << (s - 8) : 4'h0;
  endtask : sel

  // Idle lines show the inverse of the values passed in; rd passes the idle data back, so the data line flips between the written value and its inverse.
  task automatic idle(input logic [15:0] a, input logic [7:0] d);
    addr_out <= ~a;
    wdata_out <= ~d;
    psel_out <= 8'h00;
    ssel_out <= 4'h0;
  endtask : idle

  task automatic wr(input int s, input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    sel(s);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge mclk_in);
    wr_out <= 1'b0;
    idle(a, d);
    // Return off the edge so callers see the settled outputs.
    #1;
  endtask : wr

  task automatic rd(input int s, input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    sel(s);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge mclk_in);
    rd_out <= 1'b0;
    idle(a, wdata_out);
    #1;
    d = rdata_in;
  endtask : rd

  task automatic unlock(input int s);
    wr(s, {4'h0, `FSEQ_ADR_UNLK1}, `FSEQ_CODE_UNLK1);
    wr(s, {4'h0, `FSEQ_ADR_UNLK2}, `FSEQ_CODE_UNLK2);
  endtask : unlock

  task automatic cmd(input int s, input logic [7:0] c);
    unlock(s);
    wr(s, {4'h0, `FSEQ_ADR_UNLK1}, c);
  endtask : cmd
endmodule : fseq_mcu

/* bench/tb_top.sv */
`timescale 1ns/100ps
`include "fseq_cfg.svh"

module tb_top;
  import fseq_pkg::*;

  typedef struct {
    int s;
    int o;
    logic [7:0] d;
    logic flt;
    logic fl;
    logic [7:0] e;
  } fseq_row_type;

  logic mclk_in;
  logic rst_in;
  logic alg_fault_in;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic [7:0] psel;
  logic [3:0] ssel;
  logic busy_out;
  logic bypass_out;
  logic [7:0] r1;
  logic [7:0] r2;
  int err_total = 0;
  int n_tests = 0;
  // Offsets share a sector, so later rows see what earlier rows left.
  fseq_row_type rows [7] = '{'{0, 3, 8'h5a, 0, 0, 8'h5a},
    '{0, 3, 8'h50, 0, 0, 8'h50}, '{0, 3, 8'h0f, 0, 1, 8'h50},
    '{9, 15, 8'h12, 0, 0, 8'h12}, '{2, 1, 8'h3c, 1, 1, 8'hff},
    '{2, 1, 8'h3c, 0, 0, 8'h3c}, '{3, 7, 8'h81, 0, 0, 8'h81}};

  fseq_flash_sequencer #(.ADDR_W(16), .OFS_W(4), .ERASE_CYC(32'd20))
    fseq_flash_sequencer_inst (.mclk_in(mclk_in), .rst_in(rst_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .primary_sector_selects_in(psel),
    .secondary_sector_selects_in(ssel), .alg_fault_in(alg_fault_in),
    .busy_out(busy_out), .bypass_out(bypass_out));

  fseq_mcu fseq_mcu_inst (.mclk_in(mclk_in), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .psel_out(psel),
    .ssel_out(ssel), .rdata_in(rdata));

  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end

  task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop;
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic wait_idle(input int n);
    int i;
    i = 0;
    while (busy_out !== 1'b0 && i < n) begin
      @(posedge mclk_in);
      #1;
      i++;
    end
    check("busy", {7'h0, busy_out}, 8'h00);
  endtask : wait_idle

  task automatic erase_setup(input int s, input logic [7:0] last);
    fseq_mcu_inst.cmd(s, `FSEQ_CODE_ERASE);
    fseq_mcu_inst.cmd(s, last);
  endtask : erase_setup

  initial begin
    // The tests need about 14000 cycles; the limit leaves ample margin.
    #(`FSEQ_CLK_NS * 40000);
    err_total++;
    report_and_stop();
  end

  initial begin
    rst_in = 1'b1;
    alg_fault_in = 1'b0;
    repeat (16) @(posedge mclk_in);
    check("rst rdata", rdata, 8'h00);
    check("rst flags", {6'h0, busy_out, bypass_out}, 8'h00);
    rst_in <= 1'b0;
    // Bulk erase first, since the array is not cleared by reset.
    erase_setup(0, `FSEQ_CODE_BULK);
    fseq_mcu_inst.rd(5, 16'h0002, r1);
    fseq_mcu_inst.rd(5, 16'h0002, r2);
    check("bulk poll", r1 & 8'ha0, 8'h00);
    check("bulk toggle", (r1 ^ r2) & 8'h40, 8'h40);
    fseq_mcu_inst.wr(0, 16'h0000, `FSEQ_CODE_RESET);
    check("bulk busy", {7'h0, busy_out}, 8'h01);
    wait_idle(1000);
    fseq_mcu_inst.rd(7, 16'h0000, r1);
    check("erased", r1, `FSEQ_ERASED);
    foreach (rows[k]) begin
      alg_fault_in <= rows[k].flt;
      fseq_mcu_inst.cmd(rows[k].s, `FSEQ_CODE_PROG);
      fseq_mcu_inst.wr(rows[k].s, 16'(rows[k].o), rows[k].d);
      fseq_mcu_inst.rd(rows[k].s, 16'(rows[k].o), r1);
      check("prog poll", {7'h0, r1[7]}, {7'h0, ~rows[k].d[7]});
      wait_idle(400);
      alg_fault_in <= 1'b0;
      fseq_mcu_inst.rd(rows[k].s, 16'(rows[k].o), r1);
      if (rows[k].fl) begin
        check("fail flag", {7'h0, r1[5]}, 8'h01);
        fseq_mcu_inst.rd(rows[k].s, 16'(rows[k].o), r2);
        check("fail repoll", {7'h0, r2[7]}, {7'h0, ~rows[k].d[7]});
        fseq_mcu_inst.wr(rows[k].s, 16'h0000, `FSEQ_CODE_RESET);
        fseq_mcu_inst.rd(rows[k].s, 16'(rows[k].o), r1);
      end
      check("prog value", r1, rows[k].e);
    end
    // Bypass: other codes are ignored, programs need no unlock.
    fseq_mcu_inst.cmd(1, `FSEQ_CODE_BYP);
    check("byp on", {7'h0, bypass_out}, 8'h01);
    fseq_mcu_inst.wr(1, 16'h0555, `FSEQ_CODE_ERASE);
    check("byp ignore", {6'h0, busy_out, bypass_out}, 8'h01);
    fseq_mcu_inst.wr(1, 16'h0555, `FSEQ_CODE_PROG);
    fseq_mcu_inst.wr(1, 16'h0005, 8'hf0);
    wait_idle(400);
    fseq_mcu_inst.rd(1, 16'h0005, r1);
    check("byp prog", r1, 8'hf0);
    fseq_mcu_inst.wr(1, 16'h0123, `FSEQ_CODE_BYPX);
    fseq_mcu_inst.wr(1, 16'h0321, `FSEQ_CODE_BYPX2);
    check("byp off", {7'h0, bypass_out}, 8'h00);
    // A wrong sixth byte aborts the erase.
    fseq_mcu_inst.cmd(0, `FSEQ_CODE_ERASE);
    fseq_mcu_inst.cmd(0, 8'h77);
    fseq_mcu_inst.rd(0, 16'h0003, r1);
    check("abort busy", {7'h0, busy_out}, 8'h00);
    check("abort", r1, 8'h50);
    // A wrong fifth write aborts as well, so the sixth is not taken.
    fseq_mcu_inst.cmd(0, `FSEQ_CODE_ERASE);
    fseq_mcu_inst.wr(0, {4'h0, `FSEQ_ADR_UNLK1}, `FSEQ_CODE_UNLK1);
    fseq_mcu_inst.wr(0, {4'h0, `FSEQ_ADR_UNLK2}, 8'h77);
    fseq_mcu_inst.wr(0, {4'h0, `FSEQ_ADR_UNLK2}, `FSEQ_CODE_UNLK2);
    fseq_mcu_inst.wr(0, {4'h0, `FSEQ_ADR_UNLK1}, `FSEQ_CODE_BULK);
    check("abort five", {7'h0, busy_out}, 8'h00);
    // Sector erase; a second sector restarts the window.
    erase_setup(2, `FSEQ_CODE_SECT);
    fseq_mcu_inst.rd(2, 16'h0009, r1);
    check("win poll", r1 & 8'h88, 8'h00);
    repeat (2000) @(posedge mclk_in);
    fseq_mcu_inst.wr(3, 16'h0000, `FSEQ_CODE_SECT);
    repeat (2000) @(posedge mclk_in);
    fseq_mcu_inst.rd(2, 16'h000e, r1);
    check("win restart", r1 & 8'h08, 8'h00);
    wait_idle(3000);
    fseq_mcu_inst.rd(2, 16'h0001, r1);
    fseq_mcu_inst.rd(3, 16'h0007, r2);
    check("sect erased", r1 & r2, `FSEQ_ERASED);
    fseq_mcu_inst.rd(0, 16'h0003, r1);
    check("sect spare", r1, 8'h50);
    // Any write in the window other than a sector or suspend code aborts.
    erase_setup(4, `FSEQ_CODE_SECT);
    fseq_mcu_inst.wr(4, 16'h0555, `FSEQ_CODE_PROG);
    check("win abort", {7'h0, busy_out}, 8'h00);
    // Suspend right after the erase starts, then resume.
    erase_setup(4, `FSEQ_CODE_SECT);
    r1 = 8'h00;
    for (int i = 0; i < 2000 && r1[3] !== 1'b1; i++) begin
      fseq_mcu_inst.rd(4, 16'h0000, r1);
    end
    check("erase bit3", r1 & 8'h88, 8'h08);
    fseq_mcu_inst.wr(4, 16'h0000, `FSEQ_CODE_SUSP);
    repeat (8) @(posedge mclk_in);
    fseq_mcu_inst.rd(4, 16'h0000, r1);
    fseq_mcu_inst.rd(4, 16'h0000, r2);
    check("susp busy", {7'h0, busy_out}, 8'h00);
    check("susp toggle", (r1 ^ r2) & 8'h40, 8'h00);
    fseq_mcu_inst.cmd(0, `FSEQ_CODE_PROG);
    fseq_mcu_inst.wr(0, 16'h0003, 8'h00);
    fseq_mcu_inst.rd(0, 16'h0003, r1);
    check("susp refuse", r1, 8'h50);
    fseq_mcu_inst.wr(4, 16'h0000, `FSEQ_CODE_RESUME);
    check("resume", {7'h0, busy_out}, 8'h01);
    wait_idle(1000);
    fseq_mcu_inst.rd(4, 16'h0000, r1);
    check("resume done", r1, `FSEQ_ERASED);
    // Suspend inside the window ends it; a reset then frees the sequencer.
    erase_setup(5, `FSEQ_CODE_SECT);
    fseq_mcu_inst.wr(5, 16'h0000, `FSEQ_CODE_SUSP);
    repeat (8) @(posedge mclk_in);
    check("win susp", {7'h0, busy_out}, 8'h00);
    fseq_mcu_inst.wr(5, 16'h0000, `FSEQ_CODE_RESET);
    fseq_mcu_inst.cmd(5, `FSEQ_CODE_PROG);
    fseq_mcu_inst.wr(5, 16'h0002, 8'h0f);
    check("susp reset", {7'h0, busy_out}, 8'h01);
    wait_idle(400);
    // An algorithm fault during erase ends in the failure state.
    alg_fault_in <= 1'b1;
    erase_setup(6, `FSEQ_CODE_SECT);
    wait_idle(3000);
    fseq_mcu_inst.rd(6, 16'h0004, r1);
    check("erase fault", r1 & 8'ha8, 8'h20);
    alg_fault_in <= 1'b0;
    fseq_mcu_inst.wr(6, 16'h0000, `FSEQ_CODE_RESET);
    fseq_mcu_inst.rd(6, 16'h0004, r1);
    check("fault clear", r1, `FSEQ_ERASED);
    report_and_stop();
  end
endmodule : tb_top
